// ==== design/sdm_map.vh ====
`ifndef SDM_MAP_VH
`define SDM_MAP_VH

// APB register byte offsets
`define SDM_OFF_ACT    8'h00
`define SDM_OFF_MODE   8'h04
`define SDM_OFF_CMD    8'h08
`define SDM_OFF_CTRLW  8'h0C
`define SDM_OFF_STAT   8'h10
`define SDM_OFF_TVEL   8'h14
`define SDM_OFF_VSCL   8'h18
`define SDM_OFF_AOFS   8'h1C
`define SDM_OFF_POS    8'h20

// Reset values of the configuration entries, and the activation value
`define SDM_ACT_RST    8'h00
`define SDM_MODE_RST   4'h0
`define SDM_ACT_ON     8'h02

// Command register bits (write one pulses)
`define SDM_CMD_STORE   0
`define SDM_CMD_RESTART 1
// Controlword bit that asks for operation enabled
`define SDM_CW_ENABLE   0

// Mode code fields: bit 3 closed loop, bits 2:1 kind, bit 0 variant
`define SDM_MB_CL      3
`define SDM_MB_VAR     0
`define SDM_KIND_STEP  2'h0
`define SDM_KIND_TEST  2'h1
`define SDM_KIND_ANA   2'h2
`define SDM_KIND_JOY   2'h3

// Operating mode reported to the motion core
`define SDM_OP_BUS     2'h0
`define SDM_OP_STEP    2'h1
`define SDM_OP_VEL     2'h2

// Speeds in rpm
`define SDM_RPM_HI     16'h03E8
`define SDM_RPM_LO     16'h0064
`define SDM_RPM_TEST   16'h001E

// Velocity scaling factors, rpm per code in 0.16 fixed point
`define SDM_K_NRM_HI   16'h3E85
`define SDM_K_NRM_LO   16'h0641
`define SDM_K_JOY_HI   16'h7D00
`define SDM_K_JOY_LO   16'h0C80

// Analog front end: 12-bit codes, mid scale, voltages in mV
`define SDM_ADC_MID    12'h800
`define SDM_ADC_SPAN   4096
`define SDM_FS_MV      10000
`define SDM_DEAD_MV    20

`endif

// ==== design/sdm_ana_speed.v ====
`timescale 1ns/1ps
`include "sdm_map.vh"

module sdm_ana_speed #(
  parameter FS_MV   = `SDM_FS_MV,
  parameter DEAD_MV = `SDM_DEAD_MV
) (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire [11:0] ain,
  input  wire        joy,
  input  wire        lo_range,
  input  wire        dir_in,
  output reg  [15:0] speed_reg,
  output reg  [15:0] scale_reg,
  output reg  [11:0] offset_reg
);
  // Dead band in codes, rounded down so it never exceeds the stated band
  localparam integer DEAD_I = DEAD_MV * `SDM_ADC_SPAN / FS_MV;
  localparam [11:0]  DEAD   = DEAD_I[11:0];

  reg  [11:0] mag;
  reg         neg;
  reg  [15:0] factor;
  reg  [15:0] vmax;
  reg  [15:0] spd_next;
  wire [27:0] prod = mag * factor;

  // Magnitude and sign of the request
  always @* begin
    if (joy) begin
      if (ain >= `SDM_ADC_MID) begin
        mag = ain - `SDM_ADC_MID;
        neg = 1'b0;
      end else begin
        mag = `SDM_ADC_MID - ain;
        neg = 1'b1;
      end
    end else begin
      mag = ain;
      neg = dir_in;
    end
    if (joy)
      factor = lo_range ? `SDM_K_JOY_LO : `SDM_K_JOY_HI;
    else
      factor = lo_range ? `SDM_K_NRM_LO : `SDM_K_NRM_HI;
    vmax = lo_range ? `SDM_RPM_LO : `SDM_RPM_HI;
  end

  // Scale, clamp at full speed and apply dead band and sign
  always @* begin
    spd_next = {4'h0, prod[27:16]};
    if (spd_next > vmax)
      spd_next = vmax;
    if (mag <= DEAD)
      spd_next = 16'h0000;
    else if (neg)
      spd_next = 16'h0000 - spd_next;
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      speed_reg  <= 16'h0000;
      scale_reg  <= 16'h0000;
      offset_reg <= 12'h000;
    end else begin
      speed_reg  <= spd_next;
      scale_reg  <= factor;
      offset_reg <= joy ? `SDM_ADC_MID : 12'h000;
    end
  end
endmodule

// ==== design/sdm_top.v ====
// Contract
// - Mode entry 00h..0Fh, each decoded
// - 00/01, 08/09 give step and direction
// - 02/03, 0A/0B give test run CW/CCW
// - 04/05, 0C/0D analog, direction input sign
// - 06/07, 0E/0F joystick analog, mid centred
// - Codes 0..7 open loop, 8..F closed
// - Digital input 1 is the enable
// - Only enable moves drive, controlword ignored
// - New setting applies after restart only
// - Analog modes write velocity target
// - Scaling set itself for 100/1000 rpm
// - Normal analog: full voltage gives max
// - No direction signal means clockwise
// - Normal analog dead band 0..20 mV
// - Joystick: mid voltage is zero speed
// - Joystick below mid negative, above positive
// - Joystick dead band mid plus minus 20 mV
// - Test run 30 rpm while enabled
`timescale 1ns/1ps
`include "sdm_map.vh"

module sdm_top #(
  parameter FS_MV   = `SDM_FS_MV,
  parameter DEAD_MV = `SDM_DEAD_MV
) (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        din_enable,
  input  wire        din_step,
  input  wire        din_dir,
  input  wire [11:0] ain,
  output reg         sdm_active,
  output reg         drv_enable,
  output reg  [1:0]  drv_op_mode,
  output reg         drv_closed_loop,
  output reg  [15:0] drv_tgt_vel,
  output reg  [31:0] drv_pos
);
  // Configuration and drive states
  localparam [1:0] ST_LOAD = 2'h0;
  localparam [1:0] ST_IDLE = 2'h1;
  localparam [1:0] ST_RUN  = 2'h2;

  // Pending entries as written by software
  reg  [7:0]  act_reg;
  reg  [7:0]  act_next;
  reg  [3:0]  mode_reg;
  reg  [3:0]  mode_next;
  // Stored copies; they survive a soft restart
  reg  [7:0]  nv_act_reg;
  reg  [7:0]  nv_act_next;
  reg  [3:0]  nv_mode_reg;
  reg  [3:0]  nv_mode_next;
  // Active setting, taken only on restart
  reg         on_reg;
  reg         on_next;
  reg  [3:0]  amode_reg;
  reg  [3:0]  amode_next;
  // Fieldbus controlword, only heeded while special modes are off
  reg  [7:0]  ctrlw_reg;
  reg  [7:0]  ctrlw_next;
  // Drive state; the load state lasts one cycle
  reg  [1:0]  st_reg;
  reg  [1:0]  st_next;
  // Step input history and position count
  reg         step_prev_reg;
  reg  [31:0] pos_reg;
  reg  [31:0] pos_next;
  // Read data and address hit of the register bus
  reg  [31:0] rd_next;
  reg         hit;
  // Next values of the motion outputs
  reg  [15:0] vel_next;
  reg  [1:0]  opm_next;
  // Run request from whichever source owns the drive
  reg         run_req;

  // Bus phases; a transfer completes when pready is sampled high
  wire        setup  = psel & ~penable;
  wire        access = psel & penable & pready;
  wire        wr_en  = access & pwrite;
  wire        rst_cmd;
  wire        store_cmd;
  // Fields of the active mode code
  wire [1:0]  kind   = amode_reg[2:1];
  wire        cl     = amode_reg[`SDM_MB_CL];
  wire        var_b  = amode_reg[`SDM_MB_VAR];
  wire        step_edge = din_step & ~step_prev_reg;
  // Converter results
  wire [15:0] ana_speed;
  wire [15:0] ana_scale;
  wire [11:0] ana_offset;

  // Command bits are one-cycle strobes and read back as zero
  assign store_cmd = wr_en & (paddr == `SDM_OFF_CMD) &
                     pwdata[`SDM_CMD_STORE];
  assign rst_cmd   = wr_en & (paddr == `SDM_OFF_CMD) &
                     pwdata[`SDM_CMD_RESTART];

  // Analog to speed conversion, joystick and range from the mode code
  sdm_ana_speed #(
    .FS_MV   (FS_MV),
    .DEAD_MV (DEAD_MV)
  ) u_ana (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .ain        (ain),
    .joy        (kind == `SDM_KIND_JOY),
    .lo_range   (var_b),
    .dir_in     (din_dir),
    .speed_reg  (ana_speed),
    .scale_reg  (ana_scale),
    .offset_reg (ana_offset)
  );

  // Register writes; pending entries do not touch the running drive
  always @* begin
    act_next     = act_reg;
    mode_next    = mode_reg;
    ctrlw_next   = ctrlw_reg;
    nv_act_next  = nv_act_reg;
    nv_mode_next = nv_mode_reg;
    if (wr_en && paddr == `SDM_OFF_ACT)
      act_next = pwdata[7:0];
    if (wr_en && paddr == `SDM_OFF_MODE)
      mode_next = pwdata[3:0];
    if (wr_en && paddr == `SDM_OFF_CTRLW)
      ctrlw_next = pwdata[7:0];
    // Store takes the entries as they stood before this edge; a
    // write in the same cycle is saved only by the next store
    if (store_cmd) begin
      nv_act_next  = act_reg;
      nv_mode_next = mode_reg;
    end
  end

  // Drive state machine; loading the stored entries is the restart
  always @* begin
    st_next    = st_reg;
    on_next    = on_reg;
    amode_next = amode_reg;
    if (on_reg)
      run_req = din_enable;
    else
      run_req = ctrlw_reg[`SDM_CW_ENABLE];
    case (st_reg)
      ST_LOAD: begin
        // Any activation value other than 2 leaves the modes off
        on_next    = (nv_act_reg == `SDM_ACT_ON);
        amode_next = nv_mode_reg;
        st_next    = ST_IDLE;
      end
      ST_IDLE: begin
        if (run_req)
          st_next = ST_RUN;
      end
      ST_RUN: begin
        if (!run_req)
          st_next = ST_IDLE;
      end
      default: begin
        st_next = ST_LOAD;
      end
    endcase
    // Restart drops the drive and reloads the configuration; the
    // motor never sees a mode change while it turns
    if (rst_cmd)
      st_next = ST_LOAD;
  end

  // Operating mode and velocity target from the active code
  // Fieldbus mode and a stopped drive both command zero speed
  always @* begin
    opm_next = `SDM_OP_BUS;
    vel_next = 16'h0000;
    if (on_reg) begin
      case (kind)
        `SDM_KIND_STEP: begin
          opm_next = `SDM_OP_STEP;
        end
        `SDM_KIND_TEST: begin
          opm_next = `SDM_OP_VEL;
          if (st_reg == ST_RUN)
            vel_next = var_b ? 16'h0000 - `SDM_RPM_TEST
                             : `SDM_RPM_TEST;
        end
        `SDM_KIND_ANA: begin
          opm_next = `SDM_OP_VEL;
          if (st_reg == ST_RUN)
            vel_next = ana_speed;
        end
        `SDM_KIND_JOY: begin
          opm_next = `SDM_OP_VEL;
          if (st_reg == ST_RUN)
            vel_next = ana_speed;
        end
        default: begin
          opm_next = `SDM_OP_BUS;
        end
      endcase
    end
  end

  // Step counting: rising step edge moves one step, direction level
  // picks the sense; steps outside the running state are dropped
  // Limitation: a step pulse shorter than one clock is lost
  always @* begin
    pos_next = pos_reg;
    if (on_reg && kind == `SDM_KIND_STEP && st_reg == ST_RUN &&
        step_edge) begin
      if (din_dir)
        pos_next = pos_reg - 32'h00000001;
      else
        pos_next = pos_reg + 32'h00000001;
    end
  end

  // Read decode; unmapped offsets answer with an error
  // Status shows stored and active mode side by side, so software
  // can see that a restart is still pending
  always @* begin
    hit     = 1'b1;
    rd_next = 32'h00000000;
    case (paddr)
      `SDM_OFF_ACT:   rd_next = {24'h000000, act_reg};
      `SDM_OFF_MODE:  rd_next = {28'h0000000, mode_reg};
      `SDM_OFF_CMD:   rd_next = 32'h00000000;
      `SDM_OFF_CTRLW: rd_next = {24'h000000, ctrlw_reg};
      `SDM_OFF_STAT: begin
        rd_next = {20'h00000, nv_mode_reg, amode_reg, st_reg,
                   din_enable, on_reg};
      end
      `SDM_OFF_TVEL:  rd_next = {16'h0000, drv_tgt_vel};
      `SDM_OFF_VSCL:  rd_next = {16'h0000, ana_scale};
      `SDM_OFF_AOFS:  rd_next = {20'h00000, ana_offset};
      `SDM_OFF_POS:   rd_next = pos_reg;
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // APB answer is registered in the setup cycle, so every access
  // completes in its first access cycle without wait states
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit;
      if (setup && !pwrite)
        prdata <= rd_next;
      else if (access)
        prdata <= 32'h00000000;
    end
  end

  // Pending entries and controlword
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      act_reg     <= `SDM_ACT_RST;
      mode_reg    <= `SDM_MODE_RST;
      ctrlw_reg   <= 8'h00;
    end else begin
      act_reg     <= act_next;
      mode_reg    <= mode_next;
      ctrlw_reg   <= ctrlw_next;
    end
  end

  // Stored copies; only a full reset clears them, a restart keeps them
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      nv_act_reg  <= `SDM_ACT_RST;
      nv_mode_reg <= `SDM_MODE_RST;
    end else begin
      nv_act_reg  <= nv_act_next;
      nv_mode_reg <= nv_mode_next;
    end
  end

  // Active setting and drive state
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg    <= ST_LOAD;
      on_reg    <= 1'b0;
      amode_reg <= `SDM_MODE_RST;
    end else begin
      st_reg    <= st_next;
      on_reg    <= on_next;
      amode_reg <= amode_next;
    end
  end

  // Step history and position count
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      step_prev_reg <= 1'b0;
      pos_reg       <= 32'h00000000;
    end else begin
      step_prev_reg <= din_step;
      pos_reg       <= pos_next;
    end
  end

  // Status outputs to the motion core, all registered
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sdm_active      <= 1'b0;
      drv_enable      <= 1'b0;
      drv_closed_loop <= 1'b0;
    end else begin
      sdm_active      <= on_reg;
      drv_enable      <= (st_reg == ST_RUN);
      drv_closed_loop <= on_reg & cl;
    end
  end

  // Motion outputs; position shows one cycle behind the count
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      drv_op_mode     <= `SDM_OP_BUS;
      drv_tgt_vel     <= 16'h0000;
      drv_pos         <= 32'h00000000;
    end else begin
      drv_op_mode     <= opm_next;
      drv_tgt_vel     <= vel_next;
      drv_pos         <= pos_reg;
    end
  end
endmodule

// ==== tb/sdm_props.sv ====
`timescale 1ns/1ps
module sdm_props (
  input wire        mclk,
  input wire        rst_n,
  input wire        psel,
  input wire        penable,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        din_enable,
  input wire        sdm_active,
  input wire        drv_enable,
  input wire [1:0]  drv_op_mode,
  input wire [31:0] drv_pos
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Zero wait states: answer always in the cycle after setup
  a_ready_timing: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not cleared outside access");
  // Margin of six cycles covers the two-stage enable path
  a_ena_follow: assert property (
    (sdm_active && din_enable) [*6] |-> drv_enable)
    else $error("enable input did not start the drive");
  a_ena_only: assert property (
    (sdm_active && !din_enable) [*6] |-> !drv_enable)
    else $error("drive runs without enable input");
  a_pos_step: assert property (
    $changed(drv_pos) |-> (drv_pos - $past(drv_pos) == 32'h1) ||
      ($past(drv_pos) - drv_pos == 32'h1))
    else $error("position moved by more than one step");
  a_bus_idle: assert property (
    !sdm_active [*4] |-> drv_op_mode == 2'h0)
    else $error("special mode used while inactive");
endmodule

bind sdm_top sdm_props u_props (.mclk, .rst_n, .psel, .penable,
  .prdata, .pready, .pslverr, .din_enable, .sdm_active,
  .drv_enable, .drv_op_mode, .drv_pos);

// ==== tb/sdm_ext_ctrl.sv ====
`timescale 1ns/1ps
module sdm_ext_ctrl (
  input  wire        mclk,
  output reg         din_enable,
  output reg         din_step,
  output reg         din_dir,
  output reg  [11:0] ain
);
  // Idle levels from time zero
  initial begin
    din_enable = 0;
    din_step = 0;
    din_dir = 0;
    ain = 12'h000;
  end
  // Levels change just after an edge, like a clocked source
  task drive(input logic en, input logic dir, input logic [11:0] a);
    @(posedge mclk);
    din_enable <= en;
    din_dir <= dir;
    ain <= a;
  endtask
  // Direction settles first; pulse wide enough for a synchroniser
  task step(input logic dir);
    @(posedge mclk);
    din_dir <= dir;
    @(posedge mclk);
    din_step <= 1;
    repeat (2) @(posedge mclk);
    din_step <= 0;
    repeat (3) @(posedge mclk);
  endtask
endmodule

// ==== tb/tb_special_drive_mode_selector.sv ====
`timescale 1ns/1ps
`include "sdm_map.vh"
module tb_special_drive_mode_selector;
  logic        mclk = 0;
  logic        rst_n = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire         din_enable;
  wire         din_step;
  wire         din_dir;
  wire  [11:0] ain;
  wire         sdm_active;
  wire         drv_enable;
  wire  [1:0]  drv_op_mode;
  wire         drv_closed_loop;
  wire  [15:0] drv_tgt_vel;
  wire  [31:0] drv_pos;
  int          num_errors = 0;
  int          total_checks = 0;
  int          cyc = 0;
  logic [31:0] rd;
  logic        er;

  sdm_top dut (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .din_enable, .din_step,
    .din_dir, .ain, .sdm_active, .drv_enable, .drv_op_mode,
    .drv_closed_loop, .drv_tgt_vel, .drv_pos);
  sdm_ext_ctrl ext (.mclk, .din_enable, .din_step, .din_dir, .ain);

  initial forever #20 mclk = ~mclk;

  // Hang guard, well above the expected run length
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      num_errors++;
      test_done();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One APB transfer; an idle edge first keeps drivers race free
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    // Only the bench timeout ends a wait for the answer
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task t_reset;
    apb(0, `SDM_OFF_ACT, 0);
    chk(rd, 0);
    apb(1, 8'h40, 32'h5);
    chk(er, 1);
    apb(0, 8'h40, 0);
    chk(er, 1);
    chk(rd, 0);
    apb(1, `SDM_OFF_CTRLW, 1);
    repeat (6) @(posedge mclk);
    chk(drv_enable, 1);
    apb(1, `SDM_OFF_ACT, 32'h2);
    apb(1, `SDM_OFF_CMD, 32'h1);
    repeat (6) @(posedge mclk);
    chk(sdm_active, 0);
    $display("reset test done");
  endtask

  task t_mode(input logic [3:0] m);
    logic [15:0] mx;
    logic [15:0] nmx;
    logic [31:0] p;
    mx = m[0] ? `SDM_RPM_LO : `SDM_RPM_HI;
    nmx = -mx;
    apb(1, `SDM_OFF_MODE, {28'h0, m});
    apb(1, `SDM_OFF_CMD, 32'h1);
    apb(0, `SDM_OFF_STAT, 0);
    chk(rd[11:8], m);
    apb(1, `SDM_OFF_CMD, 32'h2);
    ext.drive(1, 0, 12'h000);
    apb(1, `SDM_OFF_CTRLW, 0);
    repeat (8) @(posedge mclk);
    chk({sdm_active, drv_enable}, 2'h3);
    chk(drv_closed_loop, m[3]);
    case (m[2:1])
      `SDM_KIND_STEP: begin
        chk(drv_op_mode, `SDM_OP_STEP);
        p = drv_pos;
        ext.step(0);
        ext.step(0);
        ext.step(1);
        chk(drv_pos, p + 32'h1);
      end
      `SDM_KIND_TEST: begin
        chk(drv_tgt_vel, m[0] ? 16'hFFE2 : `SDM_RPM_TEST);
        ext.drive(0, 0, 12'h000);
        repeat (8) @(posedge mclk);
        chk(drv_tgt_vel, 0);
      end
      `SDM_KIND_ANA: begin
        chk({drv_op_mode, drv_tgt_vel}, {`SDM_OP_VEL, 16'h0});
        ext.drive(1, 0, 12'h008);
        repeat (6) @(posedge mclk);
        chk(drv_tgt_vel, 0);
        ext.drive(1, 0, 12'hFFF);
        repeat (6) @(posedge mclk);
        chk(drv_tgt_vel, mx);
        ext.drive(1, 1, 12'hFFF);
        repeat (6) @(posedge mclk);
        chk(drv_tgt_vel, nmx);
        apb(0, `SDM_OFF_VSCL, 0);
        chk(rd, m[0] ? `SDM_K_NRM_LO : `SDM_K_NRM_HI);
      end
      default: begin
        chk(drv_tgt_vel, nmx);
        ext.drive(1, 0, 12'h808);
        repeat (6) @(posedge mclk);
        chk(drv_tgt_vel, 0);
        ext.drive(1, 0, 12'h7F8);
        repeat (6) @(posedge mclk);
        chk(drv_tgt_vel, 0);
        ext.drive(1, 0, 12'hFFF);
        repeat (6) @(posedge mclk);
        chk(drv_tgt_vel > 16'h0000 && drv_tgt_vel <= mx, 1);
        apb(0, `SDM_OFF_AOFS, 0);
        chk(rd, `SDM_ADC_MID);
        apb(0, `SDM_OFF_VSCL, 0);
        chk(rd, m[0] ? `SDM_K_JOY_LO : `SDM_K_JOY_HI);
      end
    endcase
    ext.drive(0, 0, 12'h000);
    apb(1, `SDM_OFF_CTRLW, 1);
    repeat (8) @(posedge mclk);
    chk(drv_enable, 0);
    $display("mode %h done", m);
  endtask

  task test_done;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1;
    t_reset();
    for (int i = 0; i < 16; i++)
      t_mode(i[3:0]);
    test_done();
  end
endmodule
